/* File: sbl_pkg.sv */
`default_nettype none
package sbl_pkg;
  // file address space and bank pointer widths
  localparam int ADDR_W = 14;
  localparam int BANK_W = 6;
  // bus register byte offsets
  localparam logic [7:0] OFS_INSTR = 8'h00;
  localparam logic [7:0] OFS_ACC = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_BANK = 8'h0c;
  localparam logic [7:0] OFS_CTRL = 8'h10;
  localparam logic [7:0] OFS_INDEX = 8'h14;
  // opcode patterns
  localparam logic [5:0] OPC_SWB = 6'h15;
  localparam logic [7:0] OPC_LIT = 8'h08;
  // opcode field positions
  localparam int BIT_DEST = 9;
  localparam int BIT_ACCESS = 8;
  // status flag positions
  localparam int FLG_C = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N = 4;
  localparam int FLG_W = 5;
  // control and instruction-status bit positions
  localparam int CTRL_EXT = 0;
  localparam int INSTR_BUSY = 16;
  // reset values
  localparam logic [7:0] ACC_RST = 8'h00;
  localparam logic [4:0] STATUS_RST = 5'h00;
  localparam logic [5:0] BANK_RST = 6'h00;
  localparam logic [13:0] INDEX_RST = 14'h0000;
  // access bank split and upper-half bank
  localparam logic [7:0] IDX_LIMIT = 8'h5f;
  localparam logic [5:0] ACC_HI_BANK = 6'h3f;
  // quarter phases of one instruction cycle
  typedef enum logic [2:0] {
    Q_IDLE = 3'b000,
    Q_DEC = 3'b001,
    Q_RD = 3'b010,
    Q_PROC = 3'b011,
    Q_WR = 3'b100
  } sbl_q_t;
endpackage
`default_nettype wire

/* File: sbl_sub_alu.sv */
`timescale 1ns/1ns
`default_nettype none
module sbl_sub_alu
  import sbl_pkg::*;
(
  input wire logic [7:0] a_in,
  input wire logic [7:0] b_in,
  input wire logic borrow_in,
  output logic [7:0] result_out,
  output logic c_out,
  output logic dc_out,
  output logic z_out,
  output logic ov_out,
  output logic n_out
);
  logic [8:0] diff9;
  logic [4:0] diff5;

  // nine-bit difference so the top bit is the borrow out
  assign diff9 = {1'b0, a_in} - {1'b0, b_in} - {8'h00, borrow_in};
  assign diff5 = {1'b0, a_in[3:0]} - {1'b0, b_in[3:0]} - {4'h0, borrow_in};
  assign result_out = diff9[7:0];
  assign c_out = ~diff9[8];
  assign dc_out = ~diff5[4];
  assign z_out = (diff9[7:0] == 8'h00);
  assign n_out = diff9[7];
  // signed wrap only when operand signs differ
  assign ov_out = (a_in[7] ^ b_in[7]) & (diff9[7] ^ a_in[7]);
endmodule
`default_nettype wire

/* File: sbl_addr_map.sv */
`timescale 1ns/1ns
`default_nettype none
module sbl_addr_map
  import sbl_pkg::*;
(
  input wire logic [7:0] f_in,
  input wire logic access_in,
  input wire logic ext_en_in,
  input wire logic [sbl_pkg::BANK_W-1:0] bank_in,
  input wire logic [sbl_pkg::ADDR_W-1:0] index_base_in,
  output logic [sbl_pkg::ADDR_W-1:0] addr_out,
  output logic indexed_out
);
  // indexed offset only applies to the low part of the access bank
  always_comb begin
    indexed_out = 1'b0;
    if (access_in) begin
      addr_out = {bank_in, f_in};
    end else if (ext_en_in && (f_in <= IDX_LIMIT)) begin
      indexed_out = 1'b1;
      addr_out = index_base_in + {6'h00, f_in};
    end else if (f_in <= IDX_LIMIT) begin
      addr_out = {BANK_RST, f_in};
    end else begin
      addr_out = {ACC_HI_BANK, f_in};
    end
  end
endmodule
`default_nettype wire

/* File: sbl_exec_top.sv */
// Functional notes
// - register subtract: acc minus file register minus inverted carry
// - destination bit zero writes acc, one writes file register
// - access bit zero uses access bank, one uses bank pointer
// - access zero, extended set on, f up to 5fh is indexed offset
// - literal subtract: literal minus acc, result into acc only
// - carry set when no borrow, cleared when a borrow occurs
// - zero flag set when eight-bit result is zero
// - negative flag follows bit 7 of result
// - literal subtract: one cycle of decode, read, process, write acc
// - register subtract: one cycle of decode, read, process, write dest
`timescale 1ns/1ns
`default_nettype none
module sbl_exec_top
(
  input wire logic core_clk_in,
  input wire logic srst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [sbl_pkg::ADDR_W-1:0] file_addr_out,
  output logic file_rd_en_out,
  input wire logic [7:0] file_rd_data_in,
  output logic file_wr_en_out,
  output logic [7:0] file_wr_data_out,
  output logic indexed_out,
  output logic busy_out
);
  import sbl_pkg::*;

  sbl_q_t state_r;
  logic [15:0] ir_r;
  logic [7:0] acc_r;
  logic [4:0] status_r;
  logic [BANK_W-1:0] bank_r;
  logic ext_en_r;
  logic [ADDR_W-1:0] index_base_r;
  logic [ADDR_W-1:0] file_addr_r;
  logic file_rd_en_r;
  logic file_wr_en_r;
  logic [7:0] file_wr_data_r;
  logic indexed_r;
  logic [31:0] rdata_r;
  logic hreadyout_r;
  logic hresp_r;
  logic busy_r;
  logic dph_wr_r;
  logic [7:0] dph_addr_r;
  logic addr_ok;
  logic wr_now;
  logic is_swb;
  logic is_lit;
  logic op_ok;
  logic [7:0] alu_a_w;
  logic [7:0] alu_b_w;
  logic alu_bin_w;
  logic [7:0] alu_res;
  logic alu_c;
  logic alu_dc;
  logic alu_z;
  logic alu_ov;
  logic alu_n;
  logic [ADDR_W-1:0] map_addr;
  logic map_indexed;
  logic [4:0] flags_nxt;

  // address phase accepted only when the bus is ready
  assign addr_ok = hsel_in & htrans_in[1] & hready_in;
  assign wr_now = dph_wr_r;
  assign is_swb = (ir_r[15:10] == OPC_SWB);
  assign is_lit = (ir_r[15:8] == OPC_LIT);
  assign op_ok = (hwdata_in[15:10] == OPC_SWB) ||
                 (hwdata_in[15:8] == OPC_LIT);

  // bus data phase bookkeeping
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      dph_wr_r <= 1'b0;
      dph_addr_r <= 8'h00;
    end else begin
      dph_wr_r <= addr_ok & hwrite_in;
      dph_addr_r <= haddr_in[7:0];
    end
  end

  // zero-wait slave: always ready, always okay, so reset changes nothing
  always_ff @(posedge core_clk_in) begin
    hreadyout_r <= 1'b1;
    hresp_r <= 1'b0;
  end

  // read data is fetched in the address phase so it stands in the data phase
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rdata_r <= 32'h0000_0000;
    end else if (addr_ok && !hwrite_in) begin
      if (haddr_in[7:0] == OFS_INSTR) begin
        rdata_r <= {15'h0000, (state_r != Q_IDLE), ir_r};
      end else if (haddr_in[7:0] == OFS_ACC) begin
        rdata_r <= {24'h000000, acc_r};
      end else if (haddr_in[7:0] == OFS_STATUS) begin
        rdata_r <= {27'h0000000, status_r};
      end else if (haddr_in[7:0] == OFS_BANK) begin
        rdata_r <= {26'h0000000, bank_r};
      end else if (haddr_in[7:0] == OFS_CTRL) begin
        rdata_r <= {31'h00000000, ext_en_r};
      end else if (haddr_in[7:0] == OFS_INDEX) begin
        rdata_r <= {18'h00000, index_base_r};
      end else begin
        rdata_r <= 32'h0000_0000;
      end
    end
  end

  // configuration registers, writable at any time
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      bank_r <= BANK_RST;
      ext_en_r <= 1'b0;
      index_base_r <= INDEX_RST;
    end else if (wr_now) begin
      if (dph_addr_r == OFS_BANK) begin
        bank_r <= hwdata_in[BANK_W-1:0];
      end else if (dph_addr_r == OFS_CTRL) begin
        ext_en_r <= hwdata_in[CTRL_EXT];
      end else if (dph_addr_r == OFS_INDEX) begin
        index_base_r <= hwdata_in[ADDR_W-1:0];
      end
    end
  end

  // quarter-phase sequencer; a new opcode is only taken while idle
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_r <= Q_IDLE;
      ir_r <= 16'h0000;
      busy_r <= 1'b0;
    end else begin
      case (state_r)
        Q_IDLE: begin
          if (wr_now && (dph_addr_r == OFS_INSTR) && op_ok) begin
            ir_r <= hwdata_in[15:0];
            state_r <= Q_DEC;
            busy_r <= 1'b1;
          end
        end
        Q_DEC: begin
          state_r <= Q_RD;
        end
        Q_RD: begin
          state_r <= Q_PROC;
        end
        Q_PROC: begin
          state_r <= Q_WR;
        end
        Q_WR: begin
          state_r <= Q_IDLE;
          busy_r <= 1'b0;
        end
        default: begin
          state_r <= Q_IDLE;
          busy_r <= 1'b0;
        end
      endcase
    end
  end

  // operand source resolution for the file operand
  sbl_addr_map u_map (
    .f_in(ir_r[7:0]),
    .access_in(ir_r[BIT_ACCESS]),
    .ext_en_in(ext_en_r),
    .bank_in(bank_r),
    .index_base_in(index_base_r),
    .addr_out(map_addr),
    .indexed_out(map_indexed)
  );

  // file read issued in the read quarter; data returns one edge later
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      file_addr_r <= {ADDR_W{1'b0}};
      indexed_r <= 1'b0;
      file_rd_en_r <= 1'b0;
    end else begin
      file_rd_en_r <= (state_r == Q_DEC) && is_swb;
      if (state_r == Q_DEC) begin
        file_addr_r <= map_addr;
        indexed_r <= map_indexed & is_swb;
      end
    end
  end

  // operand steering: literal case reverses the subtraction
  always_comb begin
    if (is_lit) begin
      alu_a_w = ir_r[7:0];
      alu_b_w = acc_r;
      alu_bin_w = 1'b0;
    end else begin
      alu_a_w = acc_r;
      alu_b_w = file_rd_data_in;
      alu_bin_w = ~status_r[FLG_C];
    end
  end

  sbl_sub_alu u_alu (
    .a_in(alu_a_w),
    .b_in(alu_b_w),
    .borrow_in(alu_bin_w),
    .result_out(alu_res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z),
    .ov_out(alu_ov),
    .n_out(alu_n)
  );

  assign flags_nxt = {alu_n, alu_ov, alu_z, alu_dc, alu_c};

  // accumulator and flags: written at the end of the process quarter
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      acc_r <= ACC_RST;
      status_r <= STATUS_RST;
    end else if (state_r == Q_PROC) begin
      status_r <= flags_nxt;
      if (is_lit || !ir_r[BIT_DEST]) begin
        acc_r <= alu_res;
      end
    end else if (wr_now && (state_r == Q_IDLE)) begin
      // software writes ignored mid-instruction to keep results coherent
      if (dph_addr_r == OFS_ACC) begin
        acc_r <= hwdata_in[7:0];
      end else if (dph_addr_r == OFS_STATUS) begin
        status_r <= hwdata_in[FLG_W-1:0];
      end
    end
  end

  // file write-back strobe stands for the whole write quarter
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      file_wr_en_r <= 1'b0;
      file_wr_data_r <= 8'h00;
    end else begin
      file_wr_en_r <= (state_r == Q_PROC) && is_swb &&
                      ir_r[BIT_DEST];
      if (state_r == Q_PROC) begin
        file_wr_data_r <= alu_res;
      end
    end
  end

  assign hrdata_out = rdata_r;
  assign hreadyout_out = hreadyout_r;
  assign hresp_out = hresp_r;
  assign file_addr_out = file_addr_r;
  assign file_rd_en_out = file_rd_en_r;
  assign file_wr_en_out = file_wr_en_r;
  assign file_wr_data_out = file_wr_data_r;
  assign indexed_out = indexed_r;
  assign busy_out = busy_r;

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  sequence s_walk;
    state_r == Q_RD ##1 state_r == Q_PROC ##1 state_r == Q_WR
      ##1 state_r == Q_IDLE;
  endsequence
  sequence s_lit_dec;
    state_r == Q_DEC && is_lit;
  endsequence

  a_swb_phases: assert property (
    (state_r == Q_DEC && is_swb) |=> file_rd_en_r ##0 s_walk)
    else $error("reg subtract phase walk broken");
  a_lit_phases: assert property (
    s_lit_dec |=> !file_rd_en_r ##0 s_walk)
    else $error("literal subtract phase walk broken");

  a_swb_math: assert property (
    (state_r == Q_PROC && is_swb) |=> file_wr_data_r ==
      8'($past(acc_r) - $past(file_rd_data_in) -
      {7'h00, ~$past(status_r[FLG_C])}))
    else $error("reg subtract result wrong");

  a_dest_file: assert property (
    (state_r == Q_PROC && is_swb && ir_r[BIT_DEST]) |=>
      file_wr_en_r && acc_r == $past(acc_r))
    else $error("file destination not honoured");
  a_dest_acc: assert property (
    (state_r == Q_PROC && is_swb && !ir_r[BIT_DEST]) |=>
      !file_wr_en_r && acc_r == file_wr_data_r)
    else $error("accumulator destination not honoured");

  a_bank_addr: assert property (
    (state_r == Q_RD && is_swb && ir_r[BIT_ACCESS]) |->
      file_addr_r == {$past(bank_r), ir_r[7:0]} && !indexed_r)
    else $error("bank pointer address wrong");
  a_indexed_addr: assert property (
    (state_r == Q_RD && is_swb && !ir_r[BIT_ACCESS] && $past(ext_en_r) &&
      ir_r[7:0] <= IDX_LIMIT) |-> indexed_r &&
      file_addr_r == ADDR_W'($past(index_base_r) + {6'h00, ir_r[7:0]}))
    else $error("indexed offset address wrong");

  a_lit_math: assert property (
    (state_r == Q_PROC && is_lit) |=> !file_wr_en_r &&
      acc_r == 8'($past(ir_r[7:0]) - $past(acc_r)))
    else $error("literal subtract result wrong");

  a_carry_flag: assert property (
    (state_r == Q_PROC) |=> status_r[FLG_C] ==
      ({1'b0, $past(alu_a_w)} >= 9'($past(alu_b_w) + $past(alu_bin_w))))
    else $error("carry flag wrong");

  a_zero_flag: assert property (
    (state_r == Q_WR) |-> status_r[FLG_Z] == (file_wr_data_r == 8'h00))
    else $error("zero flag wrong");
  a_neg_flag: assert property (
    (state_r == Q_WR) |-> status_r[FLG_N] == file_wr_data_r[7])
    else $error("negative flag wrong");
  a_wrap_flag: assert property (
    (state_r == Q_PROC) |=> status_r[FLG_OV] ==
      (($past(alu_a_w[7]) != $past(alu_b_w[7])) &&
      (file_wr_data_r[7] != $past(alu_a_w[7]))))
    else $error("signed wrap flag wrong");
endmodule
`default_nettype wire

/* File: test_sbl_exec_top.sv */
`timescale 1ns/1ns
`default_nettype none
module test_sbl_exec_top;
  import sbl_pkg::*;
  logic core_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic hsel_in = 1'b0;
  logic [31:0] haddr_in = 32'h0;
  logic [1:0] htrans_in = 2'h0;
  logic hwrite_in = 1'b0;
  logic [2:0] hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0;
  logic [7:0] file_rd_data_in = 8'h00;
  wire [31:0] hrdata_out;
  wire hreadyout_out;
  wire hresp_out;
  wire [ADDR_W-1:0] file_addr_out;
  wire file_rd_en_out;
  wire file_wr_en_out;
  wire [7:0] file_wr_data_out;
  wire indexed_out;
  wire busy_out;
  int fail_count = 0;
  int num_checks = 0;

  // 125 MHz core clock
  always #4 core_clk_in = ~core_clk_in;

  // one slave, so its ready is the bus ready
  sbl_exec_top u_dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .hsel_in(hsel_in),
    .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out), .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out),
    .file_addr_out(file_addr_out), .file_rd_en_out(file_rd_en_out),
    .file_rd_data_in(file_rd_data_in), .file_wr_en_out(file_wr_en_out),
    .file_wr_data_out(file_wr_data_out), .indexed_out(indexed_out),
    .busy_out(busy_out)
  );

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic check_word(string what, logic [31:0] exp, logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic check_count(string what, int exp, int got);
    num_checks++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // bounded wait for a sampled-high ready at a rising edge
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge core_clk_in);
    while (hreadyout_out !== 1'b1 && n < 50) begin
      n++;
      @(posedge core_clk_in);
    end
    if (n >= 50) begin
      check_count("hready wait", 0, n);
      complete_run();
    end
  endtask

  task automatic ahb_xfer(logic wr, logic [7:0] ofs, logic [31:0] wd,
                          output logic [31:0] rd);
    hsel_in <= 1'b1;
    haddr_in <= {24'h0, ofs};
    htrans_in <= 2'b10;
    hwrite_in <= wr;
    wait_ready();
    hsel_in <= 1'b0;
    htrans_in <= 2'b00;
    hwdata_in <= wd;
    wait_ready();
    rd = hrdata_out;
    check_word("hresp", 32'h0, {31'h0, hresp_out});
  endtask

  task automatic wr32(logic [7:0] ofs, logic [31:0] wd);
    logic [31:0] d;
    ahb_xfer(1'b1, ofs, wd, d);
  endtask

  task automatic rd_check(string what, logic [7:0] ofs, logic [31:0] exp);
    logic [31:0] d;
    ahb_xfer(1'b0, ofs, 32'h0, d);
    check_word(what, exp, d);
  endtask

  // {flags n,ov,z,dc,c , result} of a - b - borrow
  function automatic logic [12:0] sub_ref(logic [7:0] a, logic [7:0] b,
                                          logic bw);
    logic [8:0] r;
    logic [4:0] lo;
    r = {1'b0, a} - {1'b0, b} - {8'h00, bw};
    lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bw};
    return {r[7], (a[7] != b[7]) && (r[7] != a[7]), r[7:0] == 8'h00,
            ~lo[4], ~r[8], r[7:0]};
  endfunction

  // one instruction with preset acc, carry and file value
  task automatic do_op(logic [7:0] acc, logic c, logic [15:0] op,
                       logic [7:0] fv, logic [13:0] ea, logic ei);
    logic lit;
    logic [12:0] e;
    int nb;
    int nr;
    int nw;
    logic [7:0] acc_exp;
    lit = (op[15:8] == OPC_LIT);
    e = lit ? sub_ref(op[7:0], acc, 1'b0) : sub_ref(acc, fv, ~c);
    acc_exp = (lit || !op[BIT_DEST]) ? e[7:0] : acc;
    nb = 0;
    nr = 0;
    nw = 0;
    wr32(OFS_ACC, {24'h0, acc});
    wr32(OFS_STATUS, {31'h0, c});
    file_rd_data_in <= fv;
    wr32(OFS_INSTR, {16'h0, op});
    // watch the quarter phases after the accepting edge
    repeat (6) begin
      #1;
      nb += (busy_out === 1'b1);
      nr += (file_rd_en_out === 1'b1);
      nw += (file_wr_en_out === 1'b1);
      @(posedge core_clk_in);
    end
    check_count("busy cycles", 4, nb);
    check_count("file reads", lit ? 0 : 1, nr);
    check_count("file writes", (!lit && op[BIT_DEST]) ? 1 : 0, nw);
    check_word("wr data", {24'h0, e[7:0]},
               {24'h0, file_wr_data_out});
    if (!lit) begin
      check_word("file addr", {18'h0, ea}, {18'h0, file_addr_out});
      check_word("indexed", {31'h0, ei}, {31'h0, indexed_out});
    end
    rd_check("acc", OFS_ACC, {24'h0, acc_exp});
    rd_check("status", OFS_STATUS,
             {27'h0, e[12:8]});
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (busy_out !== 1'b0 && n < 20) begin
      n++;
      @(posedge core_clk_in);
    end
    check_count("idle wait", 1, int'(n < 20));
  endtask

  initial begin
    logic [7:0] k;
    repeat (6) @(posedge core_clk_in);
    srst_in <= 1'b0;
    // reset values, the last offset is unmapped
    for (int i = 0; i < 7; i++) begin
      k = 8'(i * 4);
      rd_check("reset reg", k, 32'h0);
    end
    $display("test reset values done");
    // literal minus acc, incl. zero, negative and signed wrap
    do_op(8'h01, 1'b0, 16'h0802, 8'h00, 14'h0, 1'b0);
    do_op(8'h02, 1'b1, 16'h0802, 8'h00, 14'h0, 1'b0);
    do_op(8'h03, 1'b0, 16'h0802, 8'h00, 14'h0, 1'b0);
    do_op(8'h01, 1'b0, 16'h0880, 8'h00, 14'h0, 1'b0);
    $display("test literal subtract done");
    // reg subtract: upper access half, then banked with borrow
    do_op(8'h02, 1'b1, 16'h5680, 8'h03, 14'h3f80, 1'b0);
    wr32(OFS_BANK, 32'h05);
    do_op(8'h02, 1'b0, 16'h5522, 8'h01, 14'h0522, 1'b0);
    do_op(8'h10, 1'b1, 16'h5610, 8'h01, 14'h0010, 1'b0);
    $display("test register subtract done");
    // extended set: indexed up to 5fh, direct above
    wr32(OFS_CTRL, 32'h1);
    wr32(OFS_INDEX, 32'h0100);
    do_op(8'h05, 1'b1, 16'h5610, 8'h02, 14'h0110, 1'b1);
    do_op(8'h05, 1'b0, 16'h565f, 8'h05, 14'h015f, 1'b1);
    do_op(8'h80, 1'b1, 16'h5460, 8'h01, 14'h3f60, 1'b0);
    $display("test indexed offset done");
    // acc write during execution and a foreign opcode are both ignored
    wr32(OFS_ACC, 32'h10);
    wr32(OFS_INSTR, 32'h0830);
    wr32(OFS_ACC, 32'h55);
    wait_idle();
    rd_check("acc busy", OFS_ACC, 32'h20);
    wr32(OFS_INSTR, 32'h0003);
    rd_check("instr kept", OFS_INSTR, 32'h0830);
    $display("test refusals done");
    complete_run();
  end
endmodule
`default_nettype wire
